// *** rtl/epp_pkg.sv ***
// Package of timing constants and types for the fast byte programmer
`default_nettype none
package epp_pkg;
    // ==========================================================
    // Clock and timing figures
    localparam int unsigned CLK_NS       = 40;      // 25 MHz clock period
    localparam int unsigned SETUP_NS     = 2000;    // Address, data, CE, OE, supply setup and data hold
    localparam int unsigned OE_VALID_NS  = 150;     // Data valid after output enable low
    localparam int unsigned FLOAT_NS     = 130;     // output_float_delay after output enable high
    localparam int unsigned PULSE_NS     = 1000000; // Initial program pulse, 1 ms
    localparam int unsigned SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned OE_VALID_CYC = (OE_VALID_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned FLOAT_CYC    = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PULSE_CYC_DOC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SYNC_CYC     = 3;       // Latency of the three-stage input synchroniser
    localparam int unsigned READ_CYC     = OE_VALID_CYC + SYNC_CYC;
    // ==========================================================
    // Algorithm constants
    localparam int unsigned MAX_PULSES   = 25;      // Limit of 1 ms pulses per byte
    localparam int unsigned OVER_MULT    = 3;       // Overprogram units per 1 ms pulse used
    localparam int unsigned TMR_W        = 22;      // Timer width, holds 1 ms at 25 MHz
    localparam int unsigned PCNT_W       = 5;
    localparam int unsigned OCNT_W       = 7;       // Holds 75 overprogram units
    localparam int unsigned ADDR_W       = 14;
    localparam int unsigned DATA_W       = 8;
    // ==========================================================
    // Controller states
    typedef enum logic [4:0] {
        ST_IDLE, ST_VCCUP, ST_VPPUP, ST_FETCH, ST_SETUP, ST_PULSE, ST_HOLD, ST_RELEASE,
        ST_VERIFY, ST_FLOAT, ST_OVER, ST_NEXT, ST_VPPDN, ST_VCCDN, ST_RFETCH, ST_RREAD,
        ST_RFLOAT, ST_IDSET, ST_IDREAD, ST_FINISH
    } epp_state_t;
endpackage
`default_nettype wire

// *** rtl/epp_tmr_if.sv ***
// Interface between the sequencer and its cycle timer
`timescale 1ns/100ps
`default_nettype none
interface epp_tmr_if;
    import epp_pkg::*;
    logic             load;     // Start a new interval
    logic [TMR_W-1:0] loadVal;  // Interval length in cycles, at least one
    logic             expired;  // Interval has run out
    modport ctrl  (output load, output loadVal, input expired);
    modport timer (input load, input loadVal, output expired);
endinterface
`default_nettype wire

// *** rtl/epp_timer.sv ***
// Down-counting interval timer for the programmer sequencer
`timescale 1ns/100ps
`default_nettype none
module epp_timer
    import epp_pkg::*;
(
    input  wire logic clock,    // 25 MHz clock
    input  wire logic reset_n,  // Synchronous reset, active low
    epp_tmr_if.timer  tmr       // Load and expiry handshake
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } epp_tmr_state_t;

    epp_tmr_state_t s_r;
    epp_tmr_state_t s_nxt;

    // ==========================================================
    // Count down; a load restarts the interval
    always_comb
    begin
        s_nxt = s_r;
        if (tmr.load)
            s_nxt.cnt = tmr.loadVal;
        else if (s_r.cnt != '0)
            s_nxt.cnt = s_r.cnt - 1'b1;
    end

    // Pure register decode: the sequencer's load depends on it, so a mask would close a loop
    assign tmr.expired = (s_r.cnt == '0);

    always_ff @(posedge clock)
    begin
        if (!reset_n)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end
endmodule
`default_nettype wire

// *** rtl/epp_programmer.sv ***
// Fast byte programmer and identification reader for a 16K x 8 UV EPROM
`timescale 1ns/100ps
`default_nettype none
module epp_programmer
    import epp_pkg::*;
#(
    parameter int unsigned PULSE_CYC = PULSE_CYC_DOC  // 1 ms in clock cycles
)
(
    input  wire logic              clock,           // 25 MHz clock
    input  wire logic              reset_n,         // Synchronous reset, active low
    input  wire logic              start,           // Pulse: begin a run
    input  wire logic              identify,        // Level at start: read id codes instead
    input  wire logic [ADDR_W-1:0] firstAddr,       // First address to program
    input  wire logic [ADDR_W-1:0] lastAddr,        // Last address to program
    output logic                   imgReq,          // Asks for the image byte at imgAddr
    output logic [ADDR_W-1:0]      imgAddr,         // Image address requested
    input  wire logic [DATA_W-1:0] imgData,         // Image byte
    input  wire logic              imgValid,        // Image byte present
    output logic                   busy,            // Run in progress
    output logic                   done,            // Pulse: run finished
    output logic                   failed,          // Device failed program or compare
    output logic [ADDR_W-1:0]      failAddr,        // First failing address
    output logic [DATA_W-1:0]      mfrCode,         // Manufacturer byte read
    output logic [DATA_W-1:0]      devCode,         // Device type byte read
    output logic [ADDR_W-1:1]      romAddrUpper,    // Address pins above bit 0
    output logic                   idByteSelect,    // Address bit 0
    output logic [DATA_W-1:0]      romDataOut,      // Data pins, driven value
    output logic                   romDataOutEn_n,  // Data pin enable, low drives
    input  wire logic [DATA_W-1:0] romDataIn,       // Data pins, sensed value
    output logic                   chipEnable_n,    // Chip enable
    output logic                   outputEnable_n,  // Output enable
    output logic                   program_strobe_n,// Program strobe
    output logic                   vppOn,           // Programming supply applied
    output logic                   vccProgLevel,    // Core supply at programming level
    output logic                   idVoltageOn      // High voltage on id address pin
);
    typedef struct packed {
        epp_state_t        st;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [PCNT_W-1:0] pulses;
        logic [OCNT_W-1:0] overLeft;
        logic              overMode;
        logic              verOk;
        logic [DATA_W-1:0] sync1;
        logic [DATA_W-1:0] sync2;
        logic [DATA_W-1:0] sync3;
        logic              done;
        logic              failed;
        logic [ADDR_W-1:0] failAddr;
        logic [DATA_W-1:0] mfr;
        logic [DATA_W-1:0] dev;
        logic [DATA_W-1:0] dOut;
        logic              dOutEn_n;
        logic              ce_n;
        logic              oe_n;
        logic              stb_n;
        logic              vpp;
        logic              vcc;
        logic              idv;
    } epp_ctl_state_t;

    epp_ctl_state_t s_r;
    epp_ctl_state_t s_nxt;
    epp_tmr_if      tmr ();

    localparam logic [TMR_W-1:0] T_SETUP = TMR_W'(SETUP_CYC);
    localparam logic [TMR_W-1:0] T_READ  = TMR_W'(READ_CYC);
    localparam logic [TMR_W-1:0] T_FLOAT = TMR_W'(FLOAT_CYC);
    localparam logic [TMR_W-1:0] T_PULSE = TMR_W'(PULSE_CYC);

    // Sensed byte counts only once the last two stages agree
    function automatic logic settled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        return a == b;
    endfunction

    // ==========================================================
    // Interval timer
    epp_timer u_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .tmr     (tmr)
    );

    // ==========================================================
    // Sequencer
    always_comb
    begin
        s_nxt       = s_r;
        tmr.load    = 1'b0;
        tmr.loadVal = T_SETUP;
        s_nxt.done  = 1'b0;
        s_nxt.sync1 = romDataIn;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        unique case (s_r.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    s_nxt.failed   = 1'b0;
                    s_nxt.failAddr = '0;
                    s_nxt.ce_n     = 1'b0;
                    tmr.load       = 1'b1;
                    if (identify)
                    begin
                        s_nxt.addr = '0;
                        s_nxt.idv  = 1'b1;
                        s_nxt.st   = ST_IDSET;
                    end
                    else
                    begin
                        s_nxt.addr = firstAddr;
                        s_nxt.vcc  = 1'b1;                  // Core supply before Vpp
                        s_nxt.st   = ST_VCCUP;
                    end
                end
            end
            ST_VCCUP:
            begin
                if (tmr.expired)
                begin
                    s_nxt.vpp = 1'b1;
                    tmr.load  = 1'b1;
                    s_nxt.st  = ST_VPPUP;
                end
            end
            ST_VPPUP:
            begin
                if (tmr.expired)
                    s_nxt.st = ST_FETCH;
            end
            ST_FETCH:
            begin
                if (imgValid)
                begin
                    s_nxt.data     = imgData;
                    s_nxt.dOut     = imgData;
                    s_nxt.dOutEn_n = 1'b0;
                    s_nxt.pulses   = '0;
                    s_nxt.overMode = 1'b0;
                    tmr.load       = 1'b1;
                    s_nxt.st       = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // Data, address, CE low and OE high all settled before the strobe
                if (tmr.expired)
                begin
                    s_nxt.stb_n = 1'b0;
                    tmr.load    = 1'b1;
                    tmr.loadVal = T_PULSE;
                    if (s_r.overMode)
                        s_nxt.st = ST_OVER;
                    else
                    begin
                        s_nxt.pulses = s_r.pulses + 1'b1;
                        s_nxt.st     = ST_PULSE;
                    end
                end
            end
            ST_PULSE:
            begin
                if (tmr.expired)
                begin
                    s_nxt.stb_n = 1'b1;
                    tmr.load    = 1'b1;
                    s_nxt.st    = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // Data hold after the strobe rises, then let go of the bus
                if (tmr.expired)
                begin
                    s_nxt.dOutEn_n = 1'b1;
                    tmr.load       = 1'b1;
                    s_nxt.st       = ST_RELEASE;
                end
            end
            ST_RELEASE:
            begin
                if (tmr.expired)
                begin
                    s_nxt.oe_n  = 1'b0;
                    tmr.load    = 1'b1;
                    tmr.loadVal = T_READ;
                    s_nxt.st    = ST_VERIFY;
                end
            end
            ST_VERIFY:
            begin
                if (tmr.expired && settled(s_r.sync2, s_r.sync3))
                begin
                    s_nxt.verOk = (s_r.sync3 == s_r.data);
                    s_nxt.oe_n  = 1'b1;
                    tmr.load    = 1'b1;
                    tmr.loadVal = T_FLOAT;
                    s_nxt.st    = ST_FLOAT;
                end
            end
            ST_FLOAT:
            begin
                if (tmr.expired)
                begin
                    if (s_r.verOk)
                    begin
                        // Three units per pulse used: 3 ms after one, 75 ms after 25
                        s_nxt.overLeft = OCNT_W'(OVER_MULT * s_r.pulses);
                        s_nxt.overMode = 1'b1;
                        s_nxt.dOutEn_n = 1'b0;
                        tmr.load       = 1'b1;
                        s_nxt.st       = ST_SETUP;
                    end
                    else if (s_r.pulses == PCNT_W'(MAX_PULSES))
                    begin
                        s_nxt.failed   = 1'b1;
                        s_nxt.failAddr = s_r.addr;
                        s_nxt.st       = ST_FINISH;
                    end
                    else
                    begin
                        s_nxt.dOutEn_n = 1'b0;
                        tmr.load       = 1'b1;
                        s_nxt.st       = ST_SETUP;
                    end
                end
            end
            ST_OVER:
            begin
                // Strobe stays low across the whole overprogram run of units
                if (tmr.expired)
                begin
                    tmr.load = 1'b1;
                    if (s_r.overLeft > OCNT_W'(1))
                    begin
                        s_nxt.overLeft = s_r.overLeft - 1'b1;
                        tmr.loadVal    = T_PULSE;
                    end
                    else
                    begin
                        s_nxt.stb_n = 1'b1;
                        s_nxt.st    = ST_NEXT;
                    end
                end
            end
            ST_NEXT:
            begin
                if (tmr.expired)
                begin
                    s_nxt.dOutEn_n = 1'b1;
                    tmr.load       = 1'b1;
                    if (s_r.addr == lastAddr)
                    begin
                        s_nxt.vpp = 1'b0;
                        s_nxt.st  = ST_VPPDN;
                    end
                    else
                    begin
                        s_nxt.addr = s_r.addr + 1'b1;
                        s_nxt.st   = ST_VPPUP;              // Setup gap before next fetch
                    end
                end
            end
            ST_VPPDN:
            begin
                // Vpp is removed before the core supply returns to normal
                if (tmr.expired)
                begin
                    s_nxt.vcc = 1'b0;
                    tmr.load  = 1'b1;
                    s_nxt.st  = ST_VCCDN;
                end
            end
            ST_VCCDN:
            begin
                if (tmr.expired)
                begin
                    s_nxt.addr = firstAddr;
                    s_nxt.st   = ST_RFETCH;
                end
            end
            ST_RFETCH:
            begin
                if (imgValid)
                begin
                    s_nxt.data  = imgData;
                    s_nxt.oe_n  = 1'b0;
                    tmr.load    = 1'b1;
                    tmr.loadVal = T_READ;
                    s_nxt.st    = ST_RREAD;
                end
            end
            ST_RREAD:
            begin
                if (tmr.expired && settled(s_r.sync2, s_r.sync3))
                begin
                    if (s_r.sync3 != s_r.data && !s_r.failed)
                    begin
                        s_nxt.failed   = 1'b1;
                        s_nxt.failAddr = s_r.addr;
                    end
                    s_nxt.oe_n  = 1'b1;
                    tmr.load    = 1'b1;
                    tmr.loadVal = T_FLOAT;
                    s_nxt.st    = ST_RFLOAT;
                end
            end
            ST_RFLOAT:
            begin
                if (tmr.expired)
                begin
                    if (s_r.addr == lastAddr)
                        s_nxt.st = ST_FINISH;
                    else
                    begin
                        s_nxt.addr = s_r.addr + 1'b1;
                        s_nxt.st   = ST_RFETCH;
                    end
                end
            end
            ST_IDSET:
            begin
                if (tmr.expired)
                begin
                    s_nxt.oe_n  = 1'b0;
                    tmr.load    = 1'b1;
                    tmr.loadVal = T_READ;
                    s_nxt.st    = ST_IDREAD;
                end
            end
            ST_IDREAD:
            begin
                if (tmr.expired && settled(s_r.sync2, s_r.sync3))
                begin
                    s_nxt.oe_n = 1'b1;
                    tmr.load   = 1'b1;
                    if (!s_r.addr[0])
                    begin
                        s_nxt.mfr     = s_r.sync3;
                        s_nxt.addr[0] = 1'b1;
                        s_nxt.st      = ST_IDSET;
                    end
                    else
                    begin
                        s_nxt.dev = s_r.sync3;
                        s_nxt.st  = ST_FINISH;
                    end
                end
            end
            ST_FINISH:
            begin
                // All supplies and enables back to the idle state
                s_nxt.ce_n     = 1'b1;
                s_nxt.oe_n     = 1'b1;
                s_nxt.stb_n    = 1'b1;
                s_nxt.dOutEn_n = 1'b1;
                s_nxt.vpp      = 1'b0;
                s_nxt.vcc      = 1'b0;
                s_nxt.idv      = 1'b0;
                s_nxt.addr     = '0;
                s_nxt.done     = 1'b1;
                s_nxt.st       = ST_IDLE;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            s_r          <= '0;
            s_r.st       <= ST_IDLE;
            s_r.ce_n     <= 1'b1;
            s_r.oe_n     <= 1'b1;
            s_r.stb_n    <= 1'b1;
            s_r.dOutEn_n <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // ==========================================================
    // Outputs
    assign imgReq           = (s_r.st == ST_FETCH) || (s_r.st == ST_RFETCH);
    assign imgAddr          = s_r.addr;
    assign busy             = (s_r.st != ST_IDLE);
    assign done             = s_r.done;
    assign failed           = s_r.failed;
    assign failAddr         = s_r.failAddr;
    assign mfrCode          = s_r.mfr;
    assign devCode          = s_r.dev;
    assign romAddrUpper     = s_r.addr[ADDR_W-1:1];
    assign idByteSelect     = s_r.addr[0];
    assign romDataOut       = s_r.dOut;
    assign romDataOutEn_n   = s_r.dOutEn_n;
    assign chipEnable_n     = s_r.ce_n;
    assign outputEnable_n   = s_r.oe_n;
    assign program_strobe_n = s_r.stb_n;
    assign vppOn            = s_r.vpp;
    assign vccProgLevel     = s_r.vcc;
    assign idVoltageOn      = s_r.idv;
endmodule
`default_nettype wire

// *** sim/epp_checker.sv ***
// Assertion checker bound to the fast byte programmer
`timescale 1ns/100ps
`default_nettype none
module epp_checker
    import epp_pkg::*;
#(
    parameter int unsigned PULSE_CYC = 20  // 1 ms in cycles
)
(
    input wire logic              clock,            // Clock
    input wire logic              reset_n,          // Reset, active low
    input wire logic              start,            // Run request
    input wire logic              busy,             // Run active
    input wire logic              done,             // End pulse
    input wire logic [ADDR_W-1:1] romAddrUpper,     // Upper address pins
    input wire logic              romDataOutEn_n,   // Data drive enable
    input wire logic              chipEnable_n,     // Chip enable
    input wire logic              outputEnable_n,   // Output enable
    input wire logic              program_strobe_n, // Program strobe
    input wire logic              vppOn,            // Programming supply
    input wire logic              vccProgLevel,     // Raised core supply
    input wire logic              idVoltageOn       // Id high voltage
);
    // ==========================================
    // Strobe low-time counter, cleared while high
    logic [31:0] lowCnt_r;
    always_ff @(posedge clock)
        lowCnt_r <= (!reset_n || program_strobe_n) ? 32'h0 : lowCnt_r + 32'h1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence s_pulse_start; $fell(program_strobe_n); endsequence
    sequence s_pulse_body; !program_strobe_n [*8]; endsequence
    // ==========================================
    // Pin modes and timing
    a_pulse_min: assert property (s_pulse_start |-> s_pulse_body) else $error("strobe pulse too short");
    a_pulse_units: assert property ($rose(program_strobe_n) |-> lowCnt_r % (PULSE_CYC + 1) == 0)
        else $error("strobe width not whole units");
    a_over_cap: assert property ($rose(program_strobe_n) |-> lowCnt_r <= 75 * (PULSE_CYC + 1))
        else $error("overprogram above cap");
    a_prog_pins: assert property (!program_strobe_n |-> !chipEnable_n && outputEnable_n && !romDataOutEn_n && vppOn)
        else $error("bad pins while strobing");
    a_verify_pins: assert property (!outputEnable_n |-> !chipEnable_n && program_strobe_n && romDataOutEn_n)
        else $error("bad pins while reading");
    a_read_hold: assert property ($fell(outputEnable_n) |-> !outputEnable_n [*8]) else $error("read too short");
    a_float_gap: assert property ($rose(outputEnable_n) |-> romDataOutEn_n [*4]) else $error("drive before float");
    a_id_pins: assert property (idVoltageOn |-> romAddrUpper == '0 && !vppOn) else $error("id address not low");
    a_supply_order: assert property (vppOn |-> vccProgLevel) else $error("vpp without vcc");
    a_start_busy: assert property (start && !busy |=> busy) else $error("start not taken");
    a_done_idle: assert property (done |-> !busy ##1 !done) else $error("done not a pulse");
endmodule
bind epp_programmer epp_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.clock, .reset_n, .start, .busy, .done,
    .romAddrUpper, .romDataOutEn_n, .chipEnable_n, .outputEnable_n, .program_strobe_n, .vppOn,
    .vccProgLevel, .idVoltageOn);
`default_nettype wire

// *** sim/epp_rom_model.sv ***
// Behavioural model of the memory device on the pin link
`timescale 1ns/100ps
`default_nettype none
module epp_rom_model
    import epp_pkg::*;
#(
    parameter logic [DATA_W-1:0] MFR_CODE = 8'hA5,  // Arbitrary value
    parameter logic [DATA_W-1:0] DEV_CODE = 8'h3C   // Arbitrary value
)
(
    input  wire logic [ADDR_W-1:1] romAddrUpper,     // Upper address
    input  wire logic              idByteSelect,     // Address bit 0
    input  wire logic [DATA_W-1:0] romDataOut,       // Controller data
    input  wire logic              romDataOutEn_n,   // Controller drives
    input  wire logic              chipEnable_n,     // Chip enable
    input  wire logic              outputEnable_n,   // Output enable
    input  wire logic              program_strobe_n, // Program strobe
    input  wire logic              vppOn,            // Programming supply
    input  wire logic              idVoltageOn,      // Id high voltage
    input  wire logic [5:0]        need,             // Pulses a byte needs
    output logic      [DATA_W-1:0] romDataIn         // Level on data wires
);
    logic [DATA_W-1:0] mem [0:16383];
    logic [5:0]        cnt [0:16383];
    logic [DATA_W-1:0] lastOut;
    wire logic [ADDR_W-1:0] addr = {romAddrUpper, idByteSelect};
    wire logic chipDrives = !chipEnable_n && !outputEnable_n;
    wire logic [DATA_W-1:0] outVal = idVoltageOn ? (idByteSelect ? DEV_CODE : MFR_CODE) : mem[addr];
    // Erased array; slow bytes need several strobes
    initial
    begin
        lastOut = 8'h00;
        for (int i = 0; i < 16384; i++)
        begin
            mem[i] = 8'hFF;
            cnt[i] = 6'h0;
        end
    end
    // A strobe counts only in program mode
    always @(posedge program_strobe_n)
        if (!chipEnable_n && outputEnable_n && vppOn)
        begin
            cnt[addr] = cnt[addr] + 6'h1;
            if (cnt[addr] >= need) mem[addr] = romDataOut;
        end
    // Released wires show the inverse, not a stale byte
    always @(outVal, chipDrives)
        if (chipDrives) lastOut = outVal;
    assign romDataIn = !romDataOutEn_n ? romDataOut : chipDrives ? outVal : ~lastOut;
endmodule
`default_nettype wire

// *** sim/eprom_fast_byte_programmer_tb_top.sv ***
// Self-checking bench for the fast byte programmer
`timescale 1ns/100ps
`default_nettype none
module eprom_fast_byte_programmer_tb_top;
    import epp_pkg::*;
    localparam int unsigned P = 20;  // Short pulse keeps the run brief
    logic clock = 1'b0, reset_n = 1'b0, start = 1'b0, identify = 1'b0, imgValid = 1'b0;
    logic [ADDR_W-1:0] firstAddr = '0, lastAddr = '0, imgAddr, failAddr;
    logic [DATA_W-1:0] imgData = '0, mfrCode, devCode, romDataOut;
    logic [5:0] need = 6'h1;
    logic imgReq, busy, done, failed, idByteSelect, romDataOutEn_n, chipEnable_n;
    logic outputEnable_n, program_strobe_n, vppOn, vccProgLevel, idVoltageOn;
    logic [ADDR_W-1:1] romAddrUpper;
    wire logic [DATA_W-1:0] romDataIn;
    logic [DATA_W-1:0] img [0:63];
    int fail_count = 0, n_compared = 0, cycles = 0, seed = 17516, lowLen = 0;
    int gotQ[$], expQ[$];
    epp_programmer #(.PULSE_CYC(P)) dut (.clock, .reset_n, .start, .identify, .firstAddr, .lastAddr, .imgReq,
        .imgAddr, .imgData, .imgValid, .busy, .done, .failed, .failAddr, .mfrCode, .devCode, .romAddrUpper,
        .idByteSelect, .romDataOut, .romDataOutEn_n, .romDataIn, .chipEnable_n, .outputEnable_n,
        .program_strobe_n, .vppOn, .vccProgLevel, .idVoltageOn);
    epp_rom_model u_rom (.romAddrUpper, .idByteSelect, .romDataOut, .romDataOutEn_n, .chipEnable_n,
        .outputEnable_n, .program_strobe_n, .vppOn, .idVoltageOn, .need, .romDataIn);
    always #20 clock = ~clock;
    // Image source with random stalls
    always @(posedge clock)
    begin
        imgValid <= imgReq && ($random(seed) & 1);
        imgData <= img[imgAddr[5:0]];
    end
    // Strobe widths and the hang limit
    always @(negedge clock)
    begin
        cycles++;
        if (!program_strobe_n) lowLen++;
        else if (lowLen > 0)
        begin
            gotQ.push_back(lowLen);
            lowLen = 0;
        end
        if (cycles == 40000)
        begin
            fail_count++;
            conclude();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input logic id, input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi, input int n);
        @(posedge clock);
        identify <= id;
        firstAddr <= lo;
        lastAddr <= hi;
        need <= n[5:0];
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
        while (done !== 1'b1) @(negedge clock);
    endtask
    // Expected pulse train from the algorithm, then the run
    task automatic prog(input int lo, input int hi, input int n);
        gotQ = {};
        expQ = {};
        for (int a = lo; a <= hi; a++)
        begin
            img[a] = 8'($random(seed)) & 8'h7F;  // Never the erased value, so a missed pulse shows
            for (int k = 0; k < n && k < 25; k++) expQ.push_back(P + 1);
            if (n > 25) break;
            expQ.push_back(3 * n * (P + 1));
        end
        run(1'b0, lo[ADDR_W-1:0], hi[ADDR_W-1:0], n);
        cmp(gotQ.size(), expQ.size());
        foreach (expQ[i]) cmp(gotQ[i], expQ[i]);
        cmp(failed, n > 25);
        if (n > 25) cmp(failAddr, lo);
        else for (int a = lo; a <= hi; a++) cmp(u_rom.mem[a], img[a]);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        run(1'b1, 14'h0, 14'h0, 1);
        cmp(mfrCode, 8'hA5);
        cmp(devCode, 8'h3C);
        prog(0, 2, 1);
        prog(4, 5, 3);
        prog(8, 8, 25);
        prog(9, 10, 26);
        prog(12, 13, 2);
        conclude();
    end
endmodule
`default_nettype wire
